//--- pnp_regs_consts.svh
// Offsets, field positions, reset values and codes of the next page register slice.
// Assumes inclusion by bare name from the design file; holds definitions only.
`ifndef PNP_REGS_CONSTS_SVH
`define PNP_REGS_CONSTS_SVH

// ----------------------------------------------------------------------------
// Address map
// ----------------------------------------------------------------------------
`define PNP_ADDR_W 12
`define PNP_PORT_BIT 4
`define PNP_OFF_LOCAL_NP 4'h0
`define PNP_OFF_PARTNER_NP 4'h4
`define PNP_OFF_GIG_CTL 4'h8

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PNP_NP_BIT 15
`define PNP_MP_BIT 13
`define PNP_ACK2_BIT 12
`define PNP_TM_HI 15
`define PNP_TM_LO 13
`define PNP_MSEN_BIT 12

// ----------------------------------------------------------------------------
// Reset values and write masks
// ----------------------------------------------------------------------------
`define PNP_LOCAL_NP_RST 16'h2001
`define PNP_PARTNER_NP_RST 16'h0000
`define PNP_GIG_CTL_RST 16'h0400
`define PNP_LOCAL_NP_WMASK 16'hB7FF
`define PNP_GIG_CTL_WMASK 16'hFC00

// ----------------------------------------------------------------------------
// Transmitter test mode codes and test pair enables
// ----------------------------------------------------------------------------
`define PNP_TM_NORMAL 3'h0
`define PNP_TM_WAVEFORM 3'h1
`define PNP_TM_JITTER_MASTER 3'h2
`define PNP_TM_JITTER_SLAVE 3'h3
`define PNP_TM_DISTORTION 3'h4
`define PNP_ALL_PAIRS 4'hF
`define PNP_NO_PAIRS 4'h0

`endif

//--- pnp_regs_pkg.sv
// Types of the next page register slice: register layouts and link-side carriers.
// Assumes nothing of its surroundings.
`default_nettype none

package pnp_pkg;

    typedef struct packed {
        logic next_page;
        logic ack;
        logic message_page;
        logic ack2;
        logic toggle;
        logic [10:0] message;
    } pnp_np_word_t;

    typedef struct packed {
        logic [2:0] test_mode;
        logic ms_manual_en;
        logic ms_value;
        logic port_type;
        logic [9:0] reserved;
    } pnp_gig_ctl_t;

    typedef enum logic [1:0] {
        pnp_sel_local,
        pnp_sel_partner,
        pnp_sel_gig,
        pnp_sel_none
    } pnp_sel_t;

    typedef struct packed {
        logic hit;
        logic port;
        pnp_sel_t sel;
    } pnp_dec_t;

    typedef struct packed {
        logic page_sent;
        logic page_rx;
        logic an_off_1000;
        pnp_np_word_t rx_word;
    } pnp_an_in_t;

    typedef struct packed {
        pnp_np_word_t tx_word;
        logic ms_manual_en;
        logic ms_force_master;
        logic port_type;
        logic [2:0] test_mode;
        logic [3:0] test_pair_en;
    } pnp_an_out_t;

    typedef struct packed {
        pnp_np_word_t local_np;
        pnp_np_word_t partner_np;
        pnp_gig_ctl_t gig;
        logic [3:0] pair_en;
    } pnp_port_state_t;

endpackage : pnp_pkg

`default_nettype wire

//--- pnp_regs.sv
// Next page and gigabit control registers for two PHY ports, reached over APB.
// Assumes the negotiation engine and transmitter run on pclk and exchange
// one-cycle pulses with this block; APB master follows the usual protocol.
//
// Behaviour
// R1: Local next page bit writable, resets zero.
// R2: Local message page bit writable, resets one.
// R3: Local acknowledge 2 bit writable, resets zero.
// R4: Toggle bit read-only, shows previous sent value.
// R5: Partner acknowledge bit read-only from received word.
// R6: Partner acknowledge 2 bit read-only from received word.
// R7: Three-bit test mode field, resets to normal.
// R8: Test codes one to four select waveforms.
// R9: Software avoids reserved test codes five-seven.
// R10: Software forces 1000 without negotiation first.
// R11: Selected test drives all four pairs.
// R12: Manual master-slave enable writable, resets zero.
// R13: Master value ignored when manual disabled.
// R14: Toggle inverts on every transmitted next page.
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "pnp_regs_consts.svh"

module pnp_regs (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PNP_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Negotiation engine and transmitter, one entry per port
    input wire pnp_pkg::pnp_an_in_t [1:0] an_in,
    output var pnp_pkg::pnp_an_out_t [1:0] an_out
);
    import pnp_pkg::*;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function automatic pnp_dec_t pnp_decode(input logic [`PNP_ADDR_W-1:0] addr);
        pnp_dec_t d;
        d.hit = 1'b0;
        d.port = addr[`PNP_PORT_BIT];
        d.sel = pnp_sel_none;
        if (addr[`PNP_ADDR_W-1:`PNP_PORT_BIT+1] == 7'h00) begin
            case (addr[`PNP_PORT_BIT-1:0])
                `PNP_OFF_LOCAL_NP: begin
                    d.hit = 1'b1;
                    d.sel = pnp_sel_local;
                end
                `PNP_OFF_PARTNER_NP: begin
                    d.hit = 1'b1;
                    d.sel = pnp_sel_partner;
                end
                `PNP_OFF_GIG_CTL: begin
                    d.hit = 1'b1;
                    d.sel = pnp_sel_gig;
                end
                default: begin
                    d.hit = 1'b0;
                end
            endcase
        end
        return d;
    endfunction : pnp_decode

    // Byte-lane merge of a write into the writable bits only.
    function automatic logic [15:0] pnp_merge(
        input logic [15:0] old,
        input logic [15:0] wdata,
        input logic [1:0] strb,
        input logic [15:0] wmask
    );
        logic [15:0] lanes;
        lanes = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
        return (old & ~lanes) | (wdata & lanes);
    endfunction : pnp_merge

    // Only codes one to four name a defined test; the rest act as normal.
    function automatic logic pnp_test_legal(input logic [2:0] code);
        return (code >= `PNP_TM_WAVEFORM) && (code <= `PNP_TM_DISTORTION);
    endfunction : pnp_test_legal

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    pnp_port_state_t [1:0] st;
    pnp_port_state_t [1:0] next_st;
    logic [31:0] next_prdata;
    logic next_pslverr;
    pnp_dec_t dec;
    logic [1:0] wr_loc;
    logic [1:0] wr_gig;
    logic [1:0] wr_par;

    // Zero-wait slave: read data and error are latched in the setup cycle.
    assign pready = 1'b1;

    always_comb begin
        dec = pnp_decode(paddr);
        next_st = st;
        next_prdata = prdata;
        next_pslverr = pslverr;
        for (int p = 0; p < 2; p++) begin
            if (an_in[p].page_sent) begin
                next_st[p].local_np.toggle = ~st[p].local_np.toggle; // R14 R4
            end
            if (an_in[p].page_rx) begin
                next_st[p].partner_np = an_in[p].rx_word; // R5 R6
            end
            // Waveforms go out only with a defined code and a forced 1000 link.
            if (pnp_test_legal(st[p].gig.test_mode) && an_in[p].an_off_1000) begin // R9 R10
                next_st[p].pair_en = `PNP_ALL_PAIRS; // R11
            end else begin
                next_st[p].pair_en = `PNP_NO_PAIRS;
            end
        end
        if (psel && !penable) begin
            next_pslverr = !dec.hit;
            next_prdata = 32'h0000_0000;
            case (dec.sel)
                pnp_sel_local: begin
                    next_prdata = {16'h0000, st[dec.port].local_np};
                end
                pnp_sel_partner: begin
                    next_prdata = {16'h0000, st[dec.port].partner_np};
                end
                pnp_sel_gig: begin
                    next_prdata = {16'h0000, st[dec.port].gig};
                end
                default: begin
                    next_prdata = 32'h0000_0000;
                end
            endcase
        end
        // Writes land at the access edge; a toggle update in the same cycle survives the merge.
        if (psel && penable && pwrite && dec.hit) begin
            case (dec.sel)
                pnp_sel_local: begin
                    next_st[dec.port].local_np = pnp_merge(next_st[dec.port].local_np,
                        pwdata[15:0], pstrb[1:0], `PNP_LOCAL_NP_WMASK); // R1 R2 R3
                end
                pnp_sel_gig: begin
                    next_st[dec.port].gig = pnp_merge(st[dec.port].gig,
                        pwdata[15:0], pstrb[1:0], `PNP_GIG_CTL_WMASK); // R7 R12
                end
                default: begin
                    next_st = next_st;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        // Reset puts both ports back to their power-up words.
        if (!presetn) begin
            for (int p = 0; p < 2; p++) begin
                st[p].local_np <= `PNP_LOCAL_NP_RST; // R1 R2 R3 R4
                st[p].partner_np <= `PNP_PARTNER_NP_RST;
                st[p].gig <= `PNP_GIG_CTL_RST; // R7 R12
                st[p].pair_en <= `PNP_NO_PAIRS;
            end
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            st <= next_st;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // ------------------------------------------------------------------------
    // Link-side outputs
    // ------------------------------------------------------------------------
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            an_out[p].tx_word = st[p].local_np;
            // The sent toggle is the opposite of the one last sent.
            an_out[p].tx_word.toggle = ~st[p].local_np.toggle; // R14
            an_out[p].ms_manual_en = st[p].gig.ms_manual_en; // R12
            an_out[p].ms_force_master = st[p].gig.ms_manual_en & st[p].gig.ms_value; // R13
            an_out[p].port_type = st[p].gig.port_type;
            if (pnp_test_legal(st[p].gig.test_mode)) begin // R8 R9
                an_out[p].test_mode = st[p].gig.test_mode;
            end else begin
                an_out[p].test_mode = `PNP_TM_NORMAL;
            end
            an_out[p].test_pair_en = st[p].pair_en; // R11
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    // Write strobes per port; the control bits all sit in the upper byte lane.
    always_comb begin
        for (int p = 0; p < 2; p++) begin
            wr_loc[p] = psel && penable && pwrite && dec.hit && (dec.port == p[0])
                && (dec.sel == pnp_sel_local) && pstrb[1];
            wr_gig[p] = psel && penable && pwrite && dec.hit && (dec.port == p[0])
                && (dec.sel == pnp_sel_gig) && pstrb[1];
            wr_par[p] = psel && penable && pwrite && dec.hit && (dec.port == p[0])
                && (dec.sel == pnp_sel_partner);
        end
    end

    for (genvar gp = 0; gp < 2; gp++) begin : g_chk
        a_np_next_write: // R1
        assert property (@(posedge pclk) disable iff (!presetn)
            wr_loc[gp] |=> st[gp].local_np.next_page == $past(pwdata[`PNP_NP_BIT]))
        else $error("Next page bit did not take the written value.");

        a_np_msg_write: // R2
        assert property (@(posedge pclk) disable iff (!presetn)
            wr_loc[gp] |=> st[gp].local_np.message_page == $past(pwdata[`PNP_MP_BIT]))
        else $error("Message page bit did not take the written value.");

        a_np_ack2_write: // R3
        assert property (@(posedge pclk) disable iff (!presetn)
            wr_loc[gp] |=> st[gp].local_np.ack2 == $past(pwdata[`PNP_ACK2_BIT]))
        else $error("Acknowledge 2 bit did not take the written value.");

        a_toggle_held: // R4
        assert property (@(posedge pclk) disable iff (!presetn)
            !an_in[gp].page_sent |=> $stable(st[gp].local_np.toggle))
        else $error("Toggle changed without a transmitted page.");

        a_toggle_flips: // R14
        assert property (@(posedge pclk) disable iff (!presetn)
            an_in[gp].page_sent |=> (st[gp].local_np.toggle != $past(st[gp].local_np.toggle))
                && (an_out[gp].tx_word.toggle == $past(st[gp].local_np.toggle)))
        else $error("Toggle did not invert after a transmitted page.");

        a_partner_ack: // R5
        assert property (@(posedge pclk) disable iff (!presetn)
            an_in[gp].page_rx |=> st[gp].partner_np.ack == $past(an_in[gp].rx_word.ack))
        else $error("Partner acknowledge not captured.");

        a_partner_ack2: // R6
        assert property (@(posedge pclk) disable iff (!presetn)
            an_in[gp].page_rx |=> st[gp].partner_np.ack2 == $past(an_in[gp].rx_word.ack2))
        else $error("Partner acknowledge 2 not captured.");

        a_test_mode_write: // R7
        assert property (@(posedge pclk) disable iff (!presetn)
            wr_gig[gp] |=> st[gp].gig.test_mode == $past(pwdata[`PNP_TM_HI:`PNP_TM_LO]))
        else $error("Test mode field did not take the written value.");

        a_test_decode: // R8
        assert property (@(posedge pclk) disable iff (!presetn)
            an_out[gp].test_mode == ((st[gp].gig.test_mode inside {`PNP_TM_WAVEFORM,
                `PNP_TM_JITTER_MASTER, `PNP_TM_JITTER_SLAVE, `PNP_TM_DISTORTION})
                ? st[gp].gig.test_mode : `PNP_TM_NORMAL))
        else $error("Test mode code decoded wrongly.");

        a_test_pairs_on: // R11
        assert property (@(posedge pclk) disable iff (!presetn)
            (pnp_test_legal(st[gp].gig.test_mode) && an_in[gp].an_off_1000)
                |=> an_out[gp].test_pair_en == `PNP_ALL_PAIRS)
        else $error("Selected test did not drive all four pairs.");

        a_test_pairs_off: // R9
        assert property (@(posedge pclk) disable iff (!presetn)
            !pnp_test_legal(st[gp].gig.test_mode) |=> an_out[gp].test_pair_en == `PNP_NO_PAIRS)
        else $error("Pairs driven without a defined test code.");

        a_ms_en_write: // R12
        assert property (@(posedge pclk) disable iff (!presetn)
            wr_gig[gp] |=> an_out[gp].ms_manual_en == $past(pwdata[`PNP_MSEN_BIT]))
        else $error("Manual master-slave enable did not take the written value.");

        a_ms_ignored: // R13
        assert property (@(posedge pclk) disable iff (!presetn)
            !an_out[gp].ms_manual_en |-> !an_out[gp].ms_force_master)
        else $error("Master value acted while manual configuration was off.");

        a_np_bits_held: // R2
        assert property (@(posedge pclk) disable iff (!presetn)
            !wr_loc[gp] |=> $stable({st[gp].local_np.next_page, st[gp].local_np.message_page,
                st[gp].local_np.ack2}))
        else $error("Local next page control bits changed without a write.");

        a_tx_next_page: // R1
        assert property (@(posedge pclk) disable iff (!presetn)
            an_out[gp].tx_word.next_page == st[gp].local_np.next_page)
        else $error("Sent word does not carry the next page bit.");

        a_tx_msg_page: // R2
        assert property (@(posedge pclk) disable iff (!presetn)
            an_out[gp].tx_word.message_page == st[gp].local_np.message_page)
        else $error("Sent word does not carry the message page bit.");

        a_tx_ack2: // R3
        assert property (@(posedge pclk) disable iff (!presetn)
            an_out[gp].tx_word.ack2 == st[gp].local_np.ack2)
        else $error("Sent word does not carry the acknowledge 2 bit.");

        a_toggle_reported: // R4
        assert property (@(posedge pclk) disable iff (!presetn)
            an_in[gp].page_sent |=> st[gp].local_np.toggle == $past(an_out[gp].tx_word.toggle))
        else $error("Stored toggle is not the value last sent.");

        a_partner_ro: // R5
        assert property (@(posedge pclk) disable iff (!presetn)
            (wr_par[gp] && !an_in[gp].page_rx) |=> $stable(st[gp].partner_np))
        else $error("Software write changed the partner word.");

        a_partner_held: // R6
        assert property (@(posedge pclk) disable iff (!presetn)
            !an_in[gp].page_rx |=> $stable(st[gp].partner_np))
        else $error("Partner word changed without a received page.");

        a_test_mode_held: // R7
        assert property (@(posedge pclk) disable iff (!presetn)
            !wr_gig[gp] |=> $stable(st[gp].gig.test_mode))
        else $error("Test mode field changed without a write.");

        a_test_out_range: // R8
        assert property (@(posedge pclk) disable iff (!presetn)
            an_out[gp].test_mode <= `PNP_TM_DISTORTION)
        else $error("A reserved test code reached the transmitter.");

        a_test_pairs_forced: // R10
        assert property (@(posedge pclk) disable iff (!presetn)
            !an_in[gp].an_off_1000 |=> an_out[gp].test_pair_en == `PNP_NO_PAIRS)
        else $error("Pairs driven while negotiation was still on.");

        a_ms_en_held: // R12
        assert property (@(posedge pclk) disable iff (!presetn)
            !wr_gig[gp] |=> $stable(an_out[gp].ms_manual_en))
        else $error("Manual master-slave enable changed without a write.");

        a_ms_master_on: // R13
        assert property (@(posedge pclk) disable iff (!presetn)
            (st[gp].gig.ms_manual_en && st[gp].gig.ms_value) |-> an_out[gp].ms_force_master)
        else $error("Master value ignored while manual configuration was on.");
    end

endmodule : pnp_regs

`default_nettype wire

//--- pnp_link_model.sv
// Behavioural negotiation engine feeding link events into the next page register slice.
// Assumes it shares pclk with the registers; page events are one-cycle pulses, the forced 1000 flag is a level.
`timescale 1ns/10ps
`default_nettype none

module pnp_link_model (
    // Clock
    input wire logic pclk,
    // Link events towards the registers
    output var pnp_pkg::pnp_an_in_t [1:0] an_in
);
    import pnp_pkg::*;

    initial begin
        an_in = '0;
    end

    task automatic send_page(input int p);
        @(posedge pclk);
        an_in[p].page_sent <= 1'b1;
        @(posedge pclk);
        an_in[p].page_sent <= 1'b0;
    endtask : send_page

    task automatic recv_page(input int p, input logic [15:0] w);
        @(posedge pclk);
        an_in[p].page_rx <= 1'b1;
        an_in[p].rx_word <= w;
        @(posedge pclk);
        an_in[p].page_rx <= 1'b0;
        // Once the word is consumed the lines stop carrying it.
        an_in[p].rx_word <= ~w;
    endtask : recv_page

    // Forced 1000 Mbps with negotiation off, which software sets before a test mode.
    task automatic set_forced(input int p, input logic v);
        @(posedge pclk);
        an_in[p].an_off_1000 <= v;
    endtask : set_forced
endmodule : pnp_link_model

`default_nettype wire

//--- phy_autoneg_next_page_regs_test.sv
// Self-checking bench of the next page register slice.
// Assumes the link model drives the engine side and APB runs on pclk.
`timescale 1ns/10ps
`default_nettype none

module phy_autoneg_next_page_regs_test;
    import pnp_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hf;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    pnp_an_in_t [1:0] an_in;
    pnp_an_out_t [1:0] an_out;
    int fails = 0;
    int check_count = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic err;

    always #4 pclk = ~pclk;

    pnp_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .an_in(an_in), .an_out(an_out));
    pnp_link_model LINK (.pclk(pclk), .an_in(an_in));

    task automatic report_and_stop();
        $display("Comparisons: %0d, mismatches: %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input string name, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, 4'hf);
        chk(name, exp, rd);
    endtask : rdchk

    task automatic test_reset();
        for (int p = 0; p < 2; p++) begin
            rdchk("local", 12'(p * 16), 32'h0000_2001);
            rdchk("partner", 12'(p * 16 + 4), 32'h0000_0000);
            rdchk("gig", 12'(p * 16 + 8), 32'h0000_0400);
            chk("tx_word", 32'h0000_2801, an_out[p].tx_word);
            chk("port_type", 32'h0000_0001, an_out[p].port_type);
        end
    endtask : test_reset

    task automatic test_local();
        apb(1'b1, 12'h010, 32'h0000_ffff, 4'hf);
        rdchk("local all", 12'h010, 32'h0000_b7ff);
        apb(1'b1, 12'h010, 32'h0000_0000, 4'hf);
        rdchk("local clr", 12'h010, 32'h0000_0000);
        apb(1'b1, 12'h010, 32'h0000_ffff, 4'h1);
        rdchk("local lane", 12'h010, 32'h0000_00ff);
    endtask : test_local

    task automatic test_toggle();
        LINK.send_page(0);
        @(negedge pclk);
        chk("tx toggle", 32'h0000_0000, an_out[0].tx_word.toggle);
        rdchk("toggle 1", 12'h000, 32'h0000_2801);
        LINK.send_page(0);
        @(negedge pclk);
        chk("tx toggle", 32'h0000_0001, an_out[0].tx_word.toggle);
        rdchk("toggle 0", 12'h000, 32'h0000_2001);
    endtask : test_toggle

    task automatic test_partner();
        logic [15:0] w [2] = '{16'h5a5a, 16'ha5a5};
        for (int i = 0; i < 2; i++) begin
            LINK.recv_page(1, w[i]);
            rdchk("partner rx", 12'h014, {16'h0000, w[i]});
            apb(1'b1, 12'h014, 32'h0000_ffff, 4'hf);
            rdchk("partner ro", 12'h014, {16'h0000, w[i]});
        end
    endtask : test_partner

    task automatic test_gig();
        logic [15:0] w;
        logic legal;
        LINK.set_forced(0, 1'b1);
        for (int c = 0; c < 5; c++) begin
            w = {3'(c), 3'b100, 10'h000};
            legal = (c >= 1 && c <= 4);
            apb(1'b1, 12'h008, {16'h0000, w}, 4'hf);
            repeat (2) @(posedge pclk);
            @(negedge pclk);
            chk("test_mode", legal ? 32'(c) : 32'h0, an_out[0].test_mode);
            chk("pair_en", legal ? 32'h0000_000f : 32'h0, an_out[0].test_pair_en);
            chk("manual_en", 32'h0000_0001, an_out[0].ms_manual_en);
            rdchk("gig rw", 12'h008, {16'h0000, w});
        end
        LINK.set_forced(0, 1'b0);
        apb(1'b1, 12'h008, 32'h0000_2000, 4'hf);
        repeat (2) @(posedge pclk);
        @(negedge pclk);
        chk("pair_en off", 32'h0000_0000, an_out[0].test_pair_en);
    endtask : test_gig

    task automatic test_ms();
        apb(1'b1, 12'h018, 32'h0000_0800, 4'hf);
        @(negedge pclk);
        chk("force_master", 32'h0000_0000, an_out[1].ms_force_master);
        chk("port_type", 32'h0000_0000, an_out[1].port_type);
        apb(1'b1, 12'h018, 32'h0000_1800, 4'hf);
        @(negedge pclk);
        chk("force_master", 32'h0000_0001, an_out[1].ms_force_master);
        chk("manual_en", 32'h0000_0001, an_out[1].ms_manual_en);
    endtask : test_ms

    task automatic test_unmapped();
        rdchk("unmapped rd", 12'h00c, 32'h0000_0000);
        chk("pready", 32'h0000_0001, pready);
        chk("slverr", 32'h0000_0001, err);
        apb(1'b1, 12'h020, 32'h0000_0000, 4'hf);
        chk("slverr", 32'h0000_0001, err);
        rdchk("no alias", 12'h000, 32'h0000_2001);
        chk("slverr", 32'h0000_0000, err);
    endtask : test_unmapped

    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            report_and_stop();
        end
    end

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        test_reset();
        test_local();
        test_toggle();
        test_partner();
        test_gig();
        test_ms();
        test_unmapped();
        report_and_stop();
    end
endmodule : phy_autoneg_next_page_regs_test

`default_nettype wire
